// *** hdl/csi_chan_if.sv ***
// link between the channel timing logic and the serial word receiver
`timescale 1ns/1ps
`default_nettype none
interface csi_chan_if;
   logic        bit_tick;
   logic        serial_bit;
   logic        req_en;
   logic        clear;
   logic        frame;
   logic        word_done;
   logic [15:0] i_word;
   logic [15:0] q_word;
   modport rx  (input bit_tick, serial_bit, req_en, clear,
                output frame, word_done, i_word, q_word);
   modport ctl (output bit_tick, serial_bit, req_en, clear,
                input frame, word_done, i_word, q_word);
endinterface
`default_nettype wire

// *** hdl/csi_pkg.sv ***
// constants shared by the channel serial input and synchronisation block
package csi_pkg;
   localparam int          NUM_CH         = 4;
   localparam int          WORD_BITS      = 16;
   localparam int          ADDR_W         = 9;
   localparam int          DATA_W         = 16;
   // per-channel register offsets, channel number in address bits 7:6
   localparam logic [5:0]  REG_FIFO_DEPTH = 6'h01;
   localparam logic [5:0]  REG_PP_DATA    = 6'h02;
   localparam logic [5:0]  REG_NCO_INC    = 6'h03;
   localparam logic [5:0]  REG_TXG_ON_A   = 6'h04;
   localparam logic [5:0]  REG_TXG_ON_B   = 6'h05;
   localparam logic [5:0]  REG_TXG_PERIOD = 6'h06;
   localparam logic [5:0]  REG_STROBE_SEL = 6'h07;
   localparam logic [5:0]  REG_TXG_CYCLES = 6'h08;
   localparam logic [5:0]  REG_UPD_MASK   = 6'h09;
   localparam logic [5:0]  REG_RX_I       = 6'h0a;
   localparam logic [5:0]  REG_RX_Q       = 6'h0b;
   localparam logic [5:0]  REG_CTRL       = 6'h0c;
   localparam logic [5:0]  REG_CH_STATUS  = 6'h0d;
   localparam logic [5:0]  REG_SER_CTRL   = 6'h11;
   localparam logic [5:0]  REG_SHUTOFF    = 6'h17;
   // global registers, address bit 8 set
   localparam logic [5:0]  REG_IRQ_STATUS = 6'h00;
   localparam logic [5:0]  REG_IRQ_MASK   = 6'h01;
   // control word bits
   localparam int          CTRL_PP_MODE   = 0;
   localparam int          CTRL_FLUSH     = 2;
   localparam int          CTRL_REQ_HOLD  = 3;
   localparam int          CTRL_TXGEN     = 4;
   localparam int          CTRL_ROUTE     = 11;
   // serial control bits
   localparam int          SER_DIV_LSB    = 0;
   localparam int          SER_RATE_32X   = 5;
   localparam int          SER_POL_SCLK   = 8;
   localparam int          SER_POL_STROBE = 9;
   localparam int          SER_POL_GATE   = 10;
   localparam int          SER_POL_UPD    = 11;
   localparam int          SER_EPOCH      = 14;
   localparam int          SHUTOFF_BIT    = 15;
   localparam int          UPD_MASK_DIV   = 0;
   localparam int          UPD_MASK_NCO   = 1;
   localparam int          NCO_32X_SHIFT  = 5;
   // strobe pin selector codes
   localparam logic [1:0]  SEL_FRAME      = 2'h0;
   localparam logic [1:0]  SEL_FIFO       = 2'h1;
   localparam logic [1:0]  SEL_UPDATE     = 2'h2;
   localparam logic [1:0]  SEL_GATE       = 2'h3;
   // reset values and counts
   localparam logic [15:0] RST_WORD       = 16'h0000;
   localparam logic [15:0] RST_FIFO_DEPTH = 16'h0008;
   localparam int          EPOCH_LEAD     = 6;
   localparam int          EPOCH_LEN_DEF  = 64;
   localparam int          FIFO_WORDS_DEF = 16;
endpackage

// *** hdl/csi_serial_rx.sv ***
// serial word receiver: frame strobe, then 16 bits of i and 16 of q, msb first
`timescale 1ns/1ps
`default_nettype none
module csi_serial_rx (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // link to channel timing
   csi_chan_if.rx    lnk
);
   typedef enum logic [1:0] {CSI_IDLE, CSI_FRAME, CSI_SHIFT} csi_rx_state_t;

   csi_rx_state_t state;
   logic [4:0]    bit_cnt;
   logic [31:0]   shreg;

   // strobe stands for exactly one serial clock period before the first bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CSI_IDLE;
         bit_cnt <= 5'h0;
      end else if (ce) begin
         if (lnk.clear) begin
            state <= CSI_IDLE;
            bit_cnt <= 5'h0;
         end else if (lnk.bit_tick) begin
            unique case (state)
               CSI_IDLE: begin
                  if (lnk.req_en) begin
                     state <= CSI_FRAME;
                  end
               end
               CSI_FRAME: begin
                  state <= CSI_SHIFT;
                  bit_cnt <= 5'h0;
               end
               CSI_SHIFT: begin
                  bit_cnt <= bit_cnt + 5'h1;
                  if (bit_cnt == 5'h1f) begin
                     state <= lnk.req_en ? CSI_FRAME : CSI_IDLE;
                  end
               end
            endcase
         end
      end
   end

   assign lnk.frame = (state == CSI_FRAME);

   // msb first shift on each serial clock rising tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= 32'h0000_0000;
      end else if (ce) begin
         if (lnk.clear) begin
            shreg <= 32'h0000_0000;
         end else if (lnk.bit_tick && state == CSI_SHIFT) begin
            shreg <= {shreg[30:0], lnk.serial_bit};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.word_done <= 1'b0;
         lnk.i_word <= csi_pkg::RST_WORD;
         lnk.q_word <= csi_pkg::RST_WORD;
      end else if (ce) begin
         lnk.word_done <= 1'b0;
         if (lnk.clear) begin
            lnk.i_word <= csi_pkg::RST_WORD;
            lnk.q_word <= csi_pkg::RST_WORD;
         end else if (lnk.bit_tick && state == CSI_SHIFT && bit_cnt == 5'h1f) begin
            lnk.i_word <= shreg[30:15];
            lnk.q_word <= {shreg[14:0], lnk.serial_bit};
            lnk.word_done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** hdl/csi_top.sv ***
// four-channel serial input, serial/sample clock and strobe pin control
// Functional notes
// - each serial input carries i then q, msb first, sampled at the serial clock rising edge.
// - the clock pin is the serial shift clock in serial mode and the sample clock in port mode.
// - the serial clock is the master clock divided by 1 to 32 or 32 times the sample clock.
// - the sample clock comes from the sample nco near 50 percent duty, sample on its fall.
// - with routing bit 11 of 0x0c clear the strobe is frame or fifo ready, else the selector rules.
// - selector 10 puts the internal update on the strobe pin, 11 the internal transmit gate.
// - bit 14 of 0x11 swaps the frame strobe for an epoch pulse six clocks before divider carry.
// - in port mode fifo ready is high while the fifo pointer is below the programmed depth.
// - transmit gate assertion clears data, loads selected config and flushes if bit 2 of 0x0c.
// - with the gate deasserted no new word is requested unless bit 3 of 0x0c is set.
// - the gate may be made inside with two duty settings alternating after a cycle count.
// - an update loads each selected config register only where its update mask bit is set.
// - clock, strobe, gate input and update input each have a per-channel polarity.
// - bit 15 of 0x17 stops serial clock and frame strobe while the gate is deasserted.
// - the frame strobe goes to the source to start each serial word transfer.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module csi_top #(
   parameter int EPOCH_LEN  = csi_pkg::EPOCH_LEN_DEF,
   parameter int FIFO_WORDS = csi_pkg::FIFO_WORDS_DEF
) (
   // clock, reset, enable
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        ce,
   // register port
   input  wire logic [csi_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [csi_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output var  logic [csi_pkg::DATA_W-1:0]  reg_rdata,
   // channel pins
   input  wire logic [csi_pkg::NUM_CH-1:0]  serial_in_x,
   input  wire logic [csi_pkg::NUM_CH-1:0]  transmit_gate_x,
   input  wire logic [csi_pkg::NUM_CH-1:0]  config_update_x,
   output var  logic [csi_pkg::NUM_CH-1:0]  serial_clock_out_x,
   output var  logic [csi_pkg::NUM_CH-1:0]  channel_strobe_out_x,
   // interrupt
   output var  logic                        irq
);
   localparam int NC = csi_pkg::NUM_CH;
   localparam logic [7:0] EP_LAST = 8'(EPOCH_LEN - 1);
   localparam logic [7:0] EP_PRE  = 8'(EPOCH_LEN - 1 - csi_pkg::EPOCH_LEAD);
   localparam logic [7:0] FIFO_MAX = 8'(FIFO_WORDS);

   function automatic logic hit(input logic [8:0] a, input logic [1:0] ch,
                                input logic [5:0] off);
      hit = !a[8] && a[7:6] == ch && a[5:0] == off;
   endfunction

   function automatic logic ghit(input logic [8:0] a, input logic [5:0] off);
      ghit = a[8] && a[7:6] == 2'h0 && a[5:0] == off;
   endfunction

   logic          rst_q1_n;
   logic          rst_sync_n;
   logic [7:0]    ep_cnt;
   logic          epoch_pulse;
   logic [15:0]   ch_rd  [NC];
   logic [NC-1:0] ev_word;
   logic [NC-1:0] ev_gate;
   logic [7:0]    irq_status;
   logic [7:0]    irq_mask;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_q1_n <= 1'b1;
         rst_sync_n <= rst_q1_n;
      end
   end

   // fixed integer divider with an early pre-carry for other devices
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ep_cnt <= 8'h00;
         epoch_pulse <= 1'b0;
      end else if (ce) begin
         ep_cnt <= (ep_cnt == EP_LAST) ? 8'h00 : ep_cnt + 8'h01;
         epoch_pulse <= (ep_cnt == EP_PRE);
      end
   end

   for (genvar c = 0; c < NC; c++) begin : gen_ch
      csi_chan_if lnk ();
      logic [15:0] ctrl, ser_ctrl, nco_shadow, nco_act, fifo_depth, shutoff;
      logic [15:0] txg_on_a, txg_on_b, txg_period, txg_cycles;
      logic [5:0]  div_act;
      logic [1:0]  strobe_sel, upd_mask;
      logic [15:0] tg_cnt, tg_cyc;
      logic        tg_phase_b, gate_int, gate_q, upd_q;
      logic        gate, upd_lvl, gate_rise, upd_rise, load_cfg, flush;
      logic [4:0]  div_cnt;
      logic [15:0] acc, acc32;
      logic        samp_q, s32_q;
      logic [7:0]  fifo_ptr;
      logic        fifo_ready, pp_mode, stop, sclk_lvl, bit_tick, frame_src, strobe_src;
      logic [5:0]  half;

      // register writes
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            ctrl <= csi_pkg::RST_WORD;
            ser_ctrl <= csi_pkg::RST_WORD;
            nco_shadow <= csi_pkg::RST_WORD;
            fifo_depth <= csi_pkg::RST_FIFO_DEPTH;
            shutoff <= csi_pkg::RST_WORD;
            txg_on_a <= csi_pkg::RST_WORD;
            txg_on_b <= csi_pkg::RST_WORD;
            txg_period <= csi_pkg::RST_WORD;
            txg_cycles <= csi_pkg::RST_WORD;
            strobe_sel <= csi_pkg::SEL_FRAME;
            upd_mask <= 2'h0;
         end else if (ce && reg_wr) begin
            if (hit(reg_addr, 2'(c), csi_pkg::REG_CTRL)) ctrl <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_SER_CTRL)) ser_ctrl <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_NCO_INC)) nco_shadow <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_FIFO_DEPTH)) fifo_depth <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_SHUTOFF)) shutoff <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_TXG_ON_A)) txg_on_a <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_TXG_ON_B)) txg_on_b <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_TXG_PERIOD)) txg_period <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_TXG_CYCLES)) txg_cycles <= reg_wdata;
            if (hit(reg_addr, 2'(c), csi_pkg::REG_STROBE_SEL)) strobe_sel <= reg_wdata[1:0];
            if (hit(reg_addr, 2'(c), csi_pkg::REG_UPD_MASK)) upd_mask <= reg_wdata[1:0];
         end
      end

      // internal gate: two on-times alternating every txg_cycles+1 periods
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            tg_cnt <= 16'h0000;
            tg_cyc <= 16'h0000;
            tg_phase_b <= 1'b0;
            gate_int <= 1'b0;
         end else if (ce) begin
            gate_int <= tg_cnt < (tg_phase_b ? txg_on_b : txg_on_a);
            if (tg_cnt >= txg_period) begin
               tg_cnt <= 16'h0000;
               if (tg_cyc >= txg_cycles) begin
                  tg_cyc <= 16'h0000;
                  tg_phase_b <= !tg_phase_b;
               end else begin
                  tg_cyc <= tg_cyc + 16'h0001;
               end
            end else begin
               tg_cnt <= tg_cnt + 16'h0001;
            end
         end
      end

      assign pp_mode = ctrl[csi_pkg::CTRL_PP_MODE];
      assign gate = ctrl[csi_pkg::CTRL_TXGEN] ? gate_int
                  : transmit_gate_x[c] ^ ser_ctrl[csi_pkg::SER_POL_GATE];
      assign upd_lvl = config_update_x[c] ^ ser_ctrl[csi_pkg::SER_POL_UPD];
      assign gate_rise = gate && !gate_q;
      assign upd_rise = upd_lvl && !upd_q;
      assign load_cfg = gate_rise || upd_rise;
      assign flush = gate_rise && ctrl[csi_pkg::CTRL_FLUSH];
      assign stop = shutoff[csi_pkg::SHUTOFF_BIT] && !gate;

      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            gate_q <= 1'b0;
            upd_q <= 1'b0;
         end else if (ce) begin
            gate_q <= gate;
            upd_q <= upd_lvl;
         end
      end

      // working config taken from shadows on gate or update, per mask bit
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            div_act <= 6'h00;
            nco_act <= csi_pkg::RST_WORD;
         end else if (ce && load_cfg) begin
            if (upd_mask[csi_pkg::UPD_MASK_DIV]) div_act <= ser_ctrl[5:0];
            if (upd_mask[csi_pkg::UPD_MASK_NCO]) nco_act <= nco_shadow;
         end
      end

      // integer divider: period div_act[4:0]+1 clocks, high for the first half
      assign half = 6'((7'(div_act[4:0]) + 7'h02) >> 1);
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            div_cnt <= 5'h00;
         end else if (ce) begin
            if (flush || div_cnt >= div_act[4:0]) begin
               div_cnt <= 5'h00;
            end else begin
               div_cnt <= div_cnt + 5'h01;
            end
         end
      end

      // sample rate nco and its 32x companion
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            acc <= 16'h0000;
            acc32 <= 16'h0000;
            samp_q <= 1'b0;
            s32_q <= 1'b0;
         end else if (ce) begin
            if (flush) begin
               acc <= 16'h0000;
               acc32 <= 16'h0000;
            end else begin
               acc <= acc + nco_act;
               acc32 <= acc32 + 16'(nco_act << csi_pkg::NCO_32X_SHIFT);
            end
            samp_q <= acc[15];
            s32_q <= acc32[15];
         end
      end

      assign sclk_lvl = div_act[csi_pkg::SER_RATE_32X] ? acc32[15]
                      : (6'(div_cnt) < half);
      assign bit_tick = !pp_mode && !stop && (div_act[csi_pkg::SER_RATE_32X]
                      ? (acc32[15] && !s32_q) : (div_cnt == 5'h00));

      // fifo pointer: port writes fill, sample clock falls drain
      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            fifo_ptr <= 8'h00;
         end else if (ce) begin
            if (gate_rise) begin
               fifo_ptr <= 8'h00;
            end else begin
               case ({reg_wr && hit(reg_addr, 2'(c), csi_pkg::REG_PP_DATA) &&
                      fifo_ptr < FIFO_MAX,
                      pp_mode && samp_q && !acc[15] && fifo_ptr != 8'h00})
                  2'b10: fifo_ptr <= fifo_ptr + 8'h01;
                  2'b01: fifo_ptr <= fifo_ptr - 8'h01;
                  default: fifo_ptr <= fifo_ptr;
               endcase
            end
         end
      end
      assign fifo_ready = 16'(fifo_ptr) < fifo_depth;

      assign lnk.bit_tick = bit_tick;
      assign lnk.serial_bit = serial_in_x[c];
      assign lnk.req_en = gate || ctrl[csi_pkg::CTRL_REQ_HOLD];
      assign lnk.clear = gate_rise;

      csi_serial_rx u_rx (
         .clk   (clk),
         .rst_n (rst_sync_n),
         .ce    (ce),
         .lnk   (lnk.rx)
      );

      // strobe source selection
      assign frame_src = stop ? 1'b0 : (ser_ctrl[csi_pkg::SER_EPOCH] ? epoch_pulse
                       : lnk.frame);
      always_comb begin
         strobe_src = pp_mode ? fifo_ready : frame_src;
         if (ctrl[csi_pkg::CTRL_ROUTE]) begin
            unique case (strobe_sel)
               csi_pkg::SEL_FRAME:  strobe_src = frame_src;
               csi_pkg::SEL_FIFO:   strobe_src = fifo_ready;
               csi_pkg::SEL_UPDATE: strobe_src = upd_lvl;
               csi_pkg::SEL_GATE:   strobe_src = gate;
            endcase
         end
      end

      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            serial_clock_out_x[c] <= 1'b0;
            channel_strobe_out_x[c] <= 1'b0;
         end else if (ce) begin
            serial_clock_out_x[c] <= (pp_mode ? acc[15] : (!stop && sclk_lvl))
                                     ^ ser_ctrl[csi_pkg::SER_POL_SCLK];
            channel_strobe_out_x[c] <= strobe_src
                                     ^ ser_ctrl[csi_pkg::SER_POL_STROBE];
         end
      end

      assign ev_word[c] = lnk.word_done;
      assign ev_gate[c] = gate_rise;

      always_comb begin
         unique case (reg_addr[5:0])
            csi_pkg::REG_CTRL:       ch_rd[c] = ctrl;
            csi_pkg::REG_SER_CTRL:   ch_rd[c] = ser_ctrl;
            csi_pkg::REG_NCO_INC:    ch_rd[c] = nco_shadow;
            csi_pkg::REG_FIFO_DEPTH: ch_rd[c] = fifo_depth;
            csi_pkg::REG_SHUTOFF:    ch_rd[c] = shutoff;
            csi_pkg::REG_TXG_ON_A:   ch_rd[c] = txg_on_a;
            csi_pkg::REG_TXG_ON_B:   ch_rd[c] = txg_on_b;
            csi_pkg::REG_TXG_PERIOD: ch_rd[c] = txg_period;
            csi_pkg::REG_TXG_CYCLES: ch_rd[c] = txg_cycles;
            csi_pkg::REG_STROBE_SEL: ch_rd[c] = {14'h0000, strobe_sel};
            csi_pkg::REG_UPD_MASK:   ch_rd[c] = {14'h0000, upd_mask};
            csi_pkg::REG_RX_I:       ch_rd[c] = lnk.i_word;
            csi_pkg::REG_RX_Q:       ch_rd[c] = lnk.q_word;
            csi_pkg::REG_CH_STATUS:  ch_rd[c] = {4'h0, gate, fifo_ready, div_act, fifo_ptr[3:0]};
            default:                 ch_rd[c] = 16'h0000;
         endcase
      end
   end

   // sticky events, write one to clear, a new event wins over the clear
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_status <= 8'h00;
         irq_mask <= 8'h00;
      end else if (ce) begin
         irq_status <= (irq_status & ~((reg_wr && ghit(reg_addr, csi_pkg::REG_IRQ_STATUS))
                       ? reg_wdata[7:0] : 8'h00)) | {ev_gate, ev_word};
         if (reg_wr && ghit(reg_addr, csi_pkg::REG_IRQ_MASK)) irq_mask <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // read data in the cycle after the strobe, zero elsewhere
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         if (!reg_rd) begin
            reg_rdata <= 16'h0000;
         end else if (!reg_addr[8]) begin
            reg_rdata <= ch_rd[reg_addr[7:6]];
         end else if (ghit(reg_addr, csi_pkg::REG_IRQ_STATUS)) begin
            reg_rdata <= {8'h00, irq_status};
         end else if (ghit(reg_addr, csi_pkg::REG_IRQ_MASK)) begin
            reg_rdata <= {8'h00, irq_mask};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/csi_src_model.sv ***
// serial data source for one channel: i then q, msb first, after each frame strobe
`timescale 1ns/1ps
`default_nettype none
module csi_src_model (
   // pins from the device
   input  wire logic        sclk,
   input  wire logic        strobe,
   // word to send
   input  wire logic [31:0] word,
   // data to the device
   output var  logic        sdata
);
   logic [31:0] sh = '0;
   int          left = 0;
   initial sdata = 1'b0;
   // data moves on the falling clock so it is steady at the sampling rise
   always @(negedge sclk) begin
      if (strobe) begin
         sh <= word;
         left <= 32;
      end else if (left > 0) begin
         sdata <= sh[31];
         sh <= sh << 1;
         left <= left - 1;
      end else begin
         sdata <= ~sdata;
      end
   end
endmodule
`default_nettype wire

// *** testbench/csi_top_sva.sv ***
// port assertions for the channel serial input block
`timescale 1ns/1ps
`default_nettype none
module csi_top_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // register port
   input wire logic [8:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // pins
   input wire logic [3:0]  transmit_gate_x,
   input wire logic [3:0]  config_update_x,
   input wire logic [3:0]  channel_strobe_out_x,
   input wire logic        irq
);
   logic [15:0] ctl0, ser0, msk;
   logic [1:0]  sel0;
   logic [2:0]  quiet;
   logic        qok;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of channel 0 routing set-up and the irq mask, quiet counts cycles since the last write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ctl0, ser0, msk, sel0, quiet} <= '0;
      end else begin
         quiet <= reg_wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
         if (reg_wr && reg_addr == 9'h00c) ctl0 <= reg_wdata;
         if (reg_wr && reg_addr == 9'h011) ser0 <= reg_wdata;
         if (reg_wr && reg_addr == 9'h101) msk <= reg_wdata;
         if (reg_wr && reg_addr == 9'h007) sel0 <= reg_wdata[1:0];
      end
   end
   assign qok = quiet > 3'h3 && ctl0[11] && !ctl0[4] && ser0[11:9] == 3'h0;
   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   chk_glob_hole: assert property ($past(reg_rd) && $past(reg_addr[8])
      && $past(reg_addr[7:6]) != 2'h0 |-> reg_rdata == 16'h0000)
      else $error("unmapped global read not zero");
   chk_off_hole: assert property ($past(reg_rd) && $past(reg_addr[5:0]) == 6'h3f
      |-> reg_rdata == 16'h0000) else $error("unmapped offset read not zero");
   chk_mask_back: assert property ($past(reg_rd) && $past(reg_addr) == 9'h101
      |-> reg_rdata[7:0] == msk[7:0]) else $error("irq mask readback wrong");
   chk_sel_back: assert property ($past(reg_rd) && $past(reg_addr) == 9'h007
      |-> reg_rdata[1:0] == sel0) else $error("selector readback wrong");
   chk_irq_off: assert property (reg_wr && reg_addr == 9'h101 && reg_wdata[7:0] == 8'h00
      |-> ##2 !irq) else $error("irq high with all sources masked");
   chk_gate_route: assert property (qok && sel0 == 2'h3
      |-> channel_strobe_out_x[0] == $past(transmit_gate_x[0]))
      else $error("strobe pin does not follow gate");
   chk_upd_route: assert property (qok && sel0 == 2'h2
      |-> channel_strobe_out_x[0] == $past(config_update_x[0]))
      else $error("strobe pin does not follow update");
endmodule
bind csi_top csi_top_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .transmit_gate_x(transmit_gate_x), .config_update_x(config_update_x),
   .channel_strobe_out_x(channel_strobe_out_x), .irq(irq));
`default_nettype wire

// *** testbench/tb_csi_top.sv ***
// self-checking bench for the channel serial input block
`timescale 1ns/1ps
`default_nettype none
module tb_csi_top;
   logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sd, irq;
   logic [8:0]  reg_addr = '0;
   logic [15:0] reg_wdata = '0, reg_rdata, d;
   logic [3:0]  gate = '0, upd = '0, sclk, strobe;
   logic [31:0] word = '0;
   logic [31:0] expq[$];
   int          n_fail = 0, total_checks = 0, t0, per;
   always #4 clk = ~clk;
   csi_top dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_in_x({3'h0, sd}), .transmit_gate_x(gate), .config_update_x(upd),
      .serial_clock_out_x(sclk), .channel_strobe_out_x(strobe), .irq(irq));
   // no tester tristate select pin here: it counts as held low
   csi_src_model src (.sclk(sclk[0]), .strobe(strobe[0]), .word(word), .sdata(sd));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [8:0] a, logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [8:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog
   initial begin
      #(8 * 30000);
      n_fail++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h8a95));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(9'h00c);
      chk("ctrl", d, 0);
      rd(9'h001);
      chk("depth", d, 32'h0000_0008);
      rd(9'h03f);
      chk("hole", d, 0);
      rd(9'h140);
      chk("global hole", d, 0);
      wr(9'h00a, 16'hffff);
      rd(9'h00a);
      chk("rx i ro", d, 0);
      $display("test registers done");
      word = $urandom();
      expq.push_back(word);
      wr(9'h011, 16'h0007);
      wr(9'h009, 16'h0001);
      wr(9'h101, 16'h0001);
      rd(9'h101);
      chk("irq mask", d, 1);
      gate[0] <= 1'b1;
      @(posedge sclk[0]);
      t0 = int'($time);
      @(posedge sclk[0]);
      chk("sclk period", 32'((int'($time) - t0) / 8), 8);
      for (per = 0; per < 2000 && irq !== 1'b1; per++) @(posedge clk);
      gate[0] <= 1'b0;
      chk("irq", irq, 1);
      rd(9'h00a);
      chk("rx i", d, expq[0][31:16]);
      rd(9'h00b);
      chk("rx q", d, expq[0][15:0]);
      repeat (400) @(posedge clk);
      wr(9'h100, 16'h00ff);
      repeat (300) @(posedge clk);
      chk("idle irq", irq, 0);
      wr(9'h101, 16'h0000);
      $display("test serial word done");
      wr(9'h00c, 16'h0800);
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            wr(9'h011, 16'(p << 9) | 16'h0007);
            wr(9'h007, 16'(s));
            rd(9'h007);
            chk("selector", d, 32'(s));
            repeat ((s > 1) ? 12 : 0) begin
               @(posedge clk);
               gate[0] <= 1'($urandom());
               upd[0] <= 1'($urandom());
            end
            @(posedge clk);
            gate[0] <= 1'b0;
            upd[0] <= 1'b1;
            repeat (6) @(posedge clk);
            chk("strobe", strobe[0], 32'(p ^ ((s == 1 || s == 2) ? 1 : 0)));
         end
      end
      $display("test strobe routing done");
      print_verdict();
   end
endmodule
`default_nettype wire
